// ===== rtl/port_mux_pkg.sv
// Shared constants for the port pin priority multiplexer.
// Summary of operation
// - Among enabled outputs on a pin, the highest priority one drives it.
// - Analog inputs join a pin only while its analog select bit is set.
// - Analog-mode pins still let enabled digital outputs drive by priority.
// - Port A 0-3 latch only; bit 4 and bit 5 follow fixed orders.
// - Port A bit 6 oscillator, clock out, latch; bit 7 oscillator input wins.
// - Port B bits 0 to 3 follow their fixed peripheral orders.
// - Port B bits 4 to 7 follow their orders; debug comes after latch.
// - Port B has eight pins, each with direction, latch and readable state.
// - Direction bit one turns the latch driver off, making an input.
// - Direction bit zero drives the latch bit onto the pin.
// - The output latch reads back at its own address, not pin levels.
// - Port B pins 7 to 4 offer optional change detection.
// - Each port B pin has its own weak pull-up enable.
// - Pull-ups drop on output pins and are all off after reset.
// - After reset B pins 5-0 are analog reading zero, 7-6 digital inputs.
`default_nettype none
package port_mux_pkg;
   // -------------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------------
   localparam logic [11:0] OFF_PIN_B  = 12'h000;
   localparam logic [11:0] OFF_DIR_B  = 12'h004;
   localparam logic [11:0] OFF_LAT_B  = 12'h008;
   localparam logic [11:0] OFF_ANA_B  = 12'h00C;
   localparam logic [11:0] OFF_PULL_B = 12'h010;
   localparam logic [11:0] OFF_CHG_B  = 12'h014;
   localparam logic [11:0] OFF_LAT_A  = 12'h018;
   localparam logic [11:0] OFF_DIR_A  = 12'h01C;
   localparam logic [11:0] OFF_ANA_A  = 12'h020;
   localparam logic [11:0] OFF_PIN_A  = 12'h024;
   // -------------------------------------------------------------------
   // Reset values and fields
   // -------------------------------------------------------------------
   localparam logic [7:0]  RST_DIR    = 8'hFF;
   localparam logic [7:0]  RST_LAT    = 8'h00;
   localparam logic [7:0]  RST_ANA_B  = 8'h3F;
   localparam logic [7:0]  RST_ANA_A  = 8'h00;
   localparam logic [7:0]  RST_PULL   = 8'h00;
   localparam logic [3:0]  RST_CHG    = 4'h0;
   localparam int          CHG_LSB    = 4;
   localparam int          PINS       = 8;
   localparam int          SLOTS      = 5;
endpackage : port_mux_pkg
`default_nettype wire

// ===== rtl/pin_arbiter.sv
// Fixed-priority selector for one pin: slot zero is the highest priority.
`default_nettype none
module pin_arbiter #(
   parameter int SLOTS = 5
) (
   input  wire logic [SLOTS-1:0] req,
   input  wire logic [SLOTS-1:0] val,
   output logic                  drive,
   output logic                  level
);
   if (SLOTS < 1)
   begin : g_bad_slots
      $error("pin_arbiter needs at least one slot.");
   end

   // -------------------------------------------------------------------
   // Selection
   // -------------------------------------------------------------------
   // Walking downward from the last slot lets a higher priority request overwrite.
   always_comb
   begin
      drive = |req;
      level = 1'b0;
      for (int k = SLOTS - 1; k >= 0; k--)
      begin
         if (req[k])
         begin
            level = val[k];
         end
      end
   end
endmodule : pin_arbiter
`default_nettype wire

// ===== rtl/port_pin_priority_mux.sv
// Port A and port B pin output arbitration with an APB register slave.
`default_nettype none
module port_pin_priority_mux #(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [7:0]        pin_a_in,
   output logic [7:0]             pin_a_out,
   output logic [7:0]             pin_a_oe_n,
   input  wire logic [7:0]        pin_b_in,
   output logic [7:0]             pin_b_out,
   output logic [7:0]             pin_b_oe_n,
   output logic [7:0]             analog_connect_a,
   output logic [7:0]             analog_connect_b,
   output logic [7:0]             pullup_on_b,
   output logic [3:0]             change_watch_b,
   input  wire logic              set_reset_latch_q,
   input  wire logic              set_reset_latch_q_en,
   input  wire logic              set_reset_latch_inverted_q,
   input  wire logic              set_reset_latch_inverted_q_en,
   input  wire logic              comparator1_output,
   input  wire logic              comparator1_output_en,
   input  wire logic              comparator2_output,
   input  wire logic              comparator2_output_en,
   input  wire logic              capture_compare5_output,
   input  wire logic              capture_compare5_output_en,
   input  wire logic              oscillator_output_pin,
   input  wire logic              oscillator_output_pin_en,
   input  wire logic              quarter_rate_clock_out,
   input  wire logic              quarter_rate_clock_out_en,
   input  wire logic              oscillator_input_pin_en,
   input  wire logic              capture_compare4_output,
   input  wire logic              capture_compare4_output_en,
   input  wire logic              i2c_clock_unit2,
   input  wire logic              i2c_clock_unit2_en,
   input  wire logic              spi_clock_unit2,
   input  wire logic              spi_clock_unit2_en,
   input  wire logic              pwm1_output_c,
   input  wire logic              pwm1_output_c_en,
   input  wire logic              i2c_data_unit2,
   input  wire logic              i2c_data_unit2_en,
   input  wire logic              pwm1_output_b,
   input  wire logic              pwm1_output_b_en,
   input  wire logic              spi_out_unit2,
   input  wire logic              spi_out_unit2_en,
   input  wire logic              capture_compare2_output,
   input  wire logic              capture_compare2_output_en,
   input  wire logic              pwm2_output_a,
   input  wire logic              pwm2_output_a_en,
   input  wire logic              pwm1_output_d,
   input  wire logic              pwm1_output_d_en,
   input  wire logic              capture_compare3_output,
   input  wire logic              capture_compare3_output_en,
   input  wire logic              pwm3_output_a,
   input  wire logic              pwm3_output_a_en,
   input  wire logic              pwm2_output_b,
   input  wire logic              pwm2_output_b_en,
   input  wire logic              programming_clock,
   input  wire logic              programming_clock_en,
   input  wire logic              serial2_transmit_clock,
   input  wire logic              serial2_transmit_clock_en,
   input  wire logic              debugger_clock,
   input  wire logic              debugger_clock_en,
   input  wire logic              programming_data,
   input  wire logic              programming_data_en,
   input  wire logic              serial2_receive_data,
   input  wire logic              serial2_receive_data_en,
   input  wire logic              debugger_data,
   input  wire logic              debugger_data_en
);
   if (ADDR_W < 6)
   begin : g_bad_addr
      $error("ADDR_W must be at least 6.");
   end

   typedef struct packed {
      logic [7:0]  dir_a;
      logic [7:0]  lat_a;
      logic [7:0]  ana_a;
      logic [7:0]  dir_b;
      logic [7:0]  lat_b;
      logic [7:0]  ana_b;
      logic [7:0]  pull_en_b;
      logic [3:0]  chg_en_b;
      logic [7:0]  sync1_a;
      logic [7:0]  sync2_a;
      logic [7:0]  sync1_b;
      logic [7:0]  sync2_b;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [7:0]  a_out;
      logic [7:0]  a_oe_n;
      logic [7:0]  b_out;
      logic [7:0]  b_oe_n;
      logic [7:0]  pull_b;
      logic [3:0]  chg_watch;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic [port_mux_pkg::SLOTS-1:0] req_m [2*port_mux_pkg::PINS];
   logic [port_mux_pkg::SLOTS-1:0] val_m [2*port_mux_pkg::PINS];
   logic [2*port_mux_pkg::PINS-1:0] arb_drive;
   logic [2*port_mux_pkg::PINS-1:0] arb_level;

   function automatic logic [11:0] word_addr(input logic [ADDR_W-1:0] a);
      word_addr = 12'(a);
   endfunction : word_addr

   // -------------------------------------------------------------------
   // Priority tables, slot zero highest
   // -------------------------------------------------------------------
   // The latch slot requests only while its direction bit is clear.
   always_comb
   begin
      for (int p = 0; p < 2 * port_mux_pkg::PINS; p++)
      begin
         req_m[p] = '0;
         val_m[p] = '0;
      end
      for (int p = 0; p < 4; p++)
      begin
         req_m[p][0] = ~st_reg.dir_a[p];
         val_m[p][0] = st_reg.lat_a[p];
      end
      req_m[4] = {1'b0, ~st_reg.dir_a[4], capture_compare5_output_en,
                  comparator1_output_en, set_reset_latch_q_en};
      val_m[4] = {1'b0, st_reg.lat_a[4], capture_compare5_output,
                  comparator1_output, set_reset_latch_q};
      req_m[5] = {2'b00, ~st_reg.dir_a[5], comparator2_output_en,
                  set_reset_latch_inverted_q_en};
      val_m[5] = {2'b00, st_reg.lat_a[5], comparator2_output,
                  set_reset_latch_inverted_q};
      req_m[6] = {2'b00, ~st_reg.dir_a[6], quarter_rate_clock_out_en,
                  oscillator_output_pin_en};
      val_m[6] = {2'b00, st_reg.lat_a[6], quarter_rate_clock_out,
                  oscillator_output_pin};
      req_m[7][0] = ~st_reg.dir_a[7];
      val_m[7][0] = st_reg.lat_a[7];
      req_m[8] = {3'b000, ~st_reg.dir_b[0], capture_compare4_output_en};
      val_m[8] = {3'b000, st_reg.lat_b[0], capture_compare4_output};
      req_m[9] = {1'b0, ~st_reg.dir_b[1], pwm1_output_c_en,
                  spi_clock_unit2_en, i2c_clock_unit2_en};
      val_m[9] = {1'b0, st_reg.lat_b[1], pwm1_output_c,
                  spi_clock_unit2, i2c_clock_unit2};
      req_m[10] = {2'b00, ~st_reg.dir_b[2], pwm1_output_b_en,
                   i2c_data_unit2_en};
      val_m[10] = {2'b00, st_reg.lat_b[2], pwm1_output_b, i2c_data_unit2};
      req_m[11] = {1'b0, ~st_reg.dir_b[3], pwm2_output_a_en,
                   capture_compare2_output_en, spi_out_unit2_en};
      val_m[11] = {1'b0, st_reg.lat_b[3], pwm2_output_a,
                   capture_compare2_output, spi_out_unit2};
      req_m[12] = {3'b000, ~st_reg.dir_b[4], pwm1_output_d_en};
      val_m[12] = {3'b000, st_reg.lat_b[4], pwm1_output_d};
      req_m[13] = {1'b0, ~st_reg.dir_b[5], pwm2_output_b_en,
                   pwm3_output_a_en, capture_compare3_output_en};
      val_m[13] = {1'b0, st_reg.lat_b[5], pwm2_output_b,
                   pwm3_output_a, capture_compare3_output};
      req_m[14] = {1'b0, debugger_clock_en, ~st_reg.dir_b[6],
                   serial2_transmit_clock_en, programming_clock_en};
      val_m[14] = {1'b0, debugger_clock, st_reg.lat_b[6],
                   serial2_transmit_clock, programming_clock};
      req_m[15] = {1'b0, debugger_data_en, ~st_reg.dir_b[7],
                   serial2_receive_data_en, programming_data_en};
      val_m[15] = {1'b0, debugger_data, st_reg.lat_b[7],
                   serial2_receive_data, programming_data};
   end

   for (genvar g = 0; g < 2 * port_mux_pkg::PINS; g++)
   begin : g_pin
      pin_arbiter #(
         .SLOTS (port_mux_pkg::SLOTS)
      ) u_arb (
         .req   (req_m[g]),
         .val   (val_m[g]),
         .drive (arb_drive[g]),
         .level (arb_level[g])
      );
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.sync1_a = pin_a_in;
      st_next.sync2_a = st_reg.sync1_a;
      st_next.sync1_b = pin_b_in;
      st_next.sync2_b = st_reg.sync1_b;
      st_next.pready = psel & ~penable;
      st_next.pslverr = 1'b0;
      st_next.prdata = '0;
      if (psel && !penable)
      begin
         case (word_addr(paddr))
            port_mux_pkg::OFF_PIN_B:
               st_next.prdata[7:0] = st_reg.sync2_b & ~st_reg.ana_b;
            port_mux_pkg::OFF_DIR_B:  st_next.prdata[7:0] = st_reg.dir_b;
            port_mux_pkg::OFF_LAT_B:  st_next.prdata[7:0] = st_reg.lat_b;
            port_mux_pkg::OFF_ANA_B:  st_next.prdata[7:0] = st_reg.ana_b;
            port_mux_pkg::OFF_PULL_B: st_next.prdata[7:0] = st_reg.pull_en_b;
            port_mux_pkg::OFF_CHG_B:
               st_next.prdata[port_mux_pkg::CHG_LSB+:4] = st_reg.chg_en_b;
            port_mux_pkg::OFF_LAT_A:  st_next.prdata[7:0] = st_reg.lat_a;
            port_mux_pkg::OFF_DIR_A:  st_next.prdata[7:0] = st_reg.dir_a;
            port_mux_pkg::OFF_ANA_A:  st_next.prdata[7:0] = st_reg.ana_a;
            port_mux_pkg::OFF_PIN_A:
               st_next.prdata[7:0] = st_reg.sync2_a & ~st_reg.ana_a;
            default:                  st_next.pslverr = 1'b1;
         endcase
      end
      // A refused setup never reaches the write decode below.
      if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr)
      begin
         case (word_addr(paddr))
            port_mux_pkg::OFF_PIN_B:  st_next.lat_b = pwdata[7:0];
            port_mux_pkg::OFF_DIR_B:  st_next.dir_b = pwdata[7:0];
            port_mux_pkg::OFF_LAT_B:  st_next.lat_b = pwdata[7:0];
            port_mux_pkg::OFF_ANA_B:  st_next.ana_b = pwdata[7:0];
            port_mux_pkg::OFF_PULL_B: st_next.pull_en_b = pwdata[7:0];
            port_mux_pkg::OFF_CHG_B:
               st_next.chg_en_b = pwdata[port_mux_pkg::CHG_LSB+:4];
            port_mux_pkg::OFF_LAT_A:  st_next.lat_a = pwdata[7:0];
            port_mux_pkg::OFF_DIR_A:  st_next.dir_a = pwdata[7:0];
            port_mux_pkg::OFF_ANA_A:  st_next.ana_a = pwdata[7:0];
            port_mux_pkg::OFF_PIN_A:  st_next.lat_a = pwdata[7:0];
            default:                  st_next.lat_a = st_reg.lat_a;
         endcase
      end
      // Analog select does not gate drive, so digital outputs keep priority.
      st_next.a_out = arb_level[7:0];
      st_next.a_oe_n = ~arb_drive[7:0];
      st_next.a_oe_n[7] = ~arb_drive[7] | oscillator_input_pin_en;
      st_next.b_out = arb_level[15:8];
      st_next.b_oe_n = ~arb_drive[15:8];
      st_next.pull_b = st_reg.pull_en_b & st_reg.dir_b & ~arb_drive[15:8];
      st_next.chg_watch = st_reg.chg_en_b & st_reg.dir_b[7:4]
                          & ~st_reg.ana_b[7:4];
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
         st_reg.dir_a <= port_mux_pkg::RST_DIR;
         st_reg.lat_a <= port_mux_pkg::RST_LAT;
         st_reg.ana_a <= port_mux_pkg::RST_ANA_A;
         st_reg.dir_b <= port_mux_pkg::RST_DIR;
         st_reg.lat_b <= port_mux_pkg::RST_LAT;
         st_reg.ana_b <= port_mux_pkg::RST_ANA_B;
         st_reg.pull_en_b <= port_mux_pkg::RST_PULL;
         st_reg.chg_en_b <= port_mux_pkg::RST_CHG;
         st_reg.a_oe_n <= 8'hFF;
         st_reg.b_oe_n <= 8'hFF;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign pin_a_out = st_reg.a_out;
   assign pin_a_oe_n = st_reg.a_oe_n;
   assign pin_b_out = st_reg.b_out;
   assign pin_b_oe_n = st_reg.b_oe_n;
   assign analog_connect_a = st_reg.ana_a;
   assign analog_connect_b = st_reg.ana_b;
   assign pullup_on_b = st_reg.pull_b;
   assign change_watch_b = st_reg.chg_watch;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_highest_wins: assert property (
      i2c_clock_unit2_en |=> !pin_b_oe_n[1] && pin_b_out[1] == $past(i2c_clock_unit2))
      else $error("Highest priority request did not win on port B pin 1.");
   a_second_slot: assert property (
      !i2c_clock_unit2_en && spi_clock_unit2_en
      |=> pin_b_out[1] == $past(spi_clock_unit2))
      else $error("SPI clock did not drive port B pin 1.");
   a_analog_follow: assert property (
      psel && penable && pready && pwrite && !pslverr
      && word_addr(paddr) == port_mux_pkg::OFF_ANA_B
      |=> analog_connect_b == $past(pwdata[7:0]))
      else $error("Analog connect does not follow the select register.");
   a_analog_drive: assert property (
      st_reg.ana_b[2] && i2c_data_unit2_en |=> !pin_b_oe_n[2])
      else $error("Analog pin refused a digital output.");
   a_porta_order: assert property (
      set_reset_latch_q_en |=> pin_a_out[4] == $past(set_reset_latch_q) && !pin_a_oe_n[4])
      else $error("Port A pin 4 not given to the latch Q output.");
   a_osc_input: assert property (
      oscillator_input_pin_en |=> pin_a_oe_n[7])
      else $error("Oscillator input pin still driven.");
   a_debug_last: assert property (
      !programming_clock_en && !serial2_transmit_clock_en && st_reg.dir_b[6]
      && debugger_clock_en |=> pin_b_out[6] == $past(debugger_clock))
      else $error("Debug clock not driving port B pin 6.");
   a_dir_input: assert property (
      st_reg.dir_b[0] && !capture_compare4_output_en |=> pin_b_oe_n[0])
      else $error("Input pin still driven.");
   a_dir_output: assert property (
      !st_reg.dir_b[0] && !capture_compare4_output_en
      |=> !pin_b_oe_n[0] && pin_b_out[0] == $past(st_reg.lat_b[0]))
      else $error("Output pin not driving its latch bit.");
   a_latch_read: assert property (
      psel && !penable && word_addr(paddr) == port_mux_pkg::OFF_LAT_B
      |=> pready && prdata[7:0] == $past(st_reg.lat_b))
      else $error("Latch read back wrong.");
   a_pullup_off: assert property (
      !st_reg.dir_b[3] |=> !pullup_on_b[3])
      else $error("Pull-up left on for an output pin.");
   a_pin_write: assert property (
      psel && penable && pready && pwrite && !pslverr
      && word_addr(paddr) == port_mux_pkg::OFF_PIN_B
      |=> st_reg.lat_b == $past(pwdata[7:0]))
      else $error("Pin state write did not reach the latch.");
endmodule : port_pin_priority_mux
`default_nettype wire

// ===== dv/pad_model.sv
// Pad model for the port pins: external drive, pull-up and release of each line.
`default_nettype none
module pad_model (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] pullup_on,
   input  wire logic [7:0] ext_drv,
   input  wire logic [7:0] ext_lvl,
   output logic [7:0]      pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // A released line without a pull-up shows the inverse of pin_out, so it reads high once no slot requests and pin_out is low.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i]
                     : ext_drv[i] ? ext_lvl[i]
                     : pullup_on[i] | ~pin_out[i];
      end
   end
endmodule : pad_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the port pin priority multiplexer and its APB registers.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, ana_a, ana_b, pull_b, ext_drv, ext_lvl;
   logic [3:0]  watch_b;
   logic [26:0] en, dv;
   int          miscompares, comparisons;
   // -------------------------------------------------------------------
   // Instances
   // -------------------------------------------------------------------
   port_pin_priority_mux i_port_pin_priority_mux (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_a_in(a_in), .pin_a_out(a_out), .pin_a_oe_n(a_oe_n), .pin_b_in(b_in),
      .pin_b_out(b_out), .pin_b_oe_n(b_oe_n), .analog_connect_a(ana_a),
      .analog_connect_b(ana_b),
      .pullup_on_b(pull_b), .change_watch_b(watch_b),
      .set_reset_latch_q(dv[0]), .set_reset_latch_q_en(en[0]),
      .set_reset_latch_inverted_q(dv[1]), .set_reset_latch_inverted_q_en(en[1]),
      .comparator1_output(dv[2]), .comparator1_output_en(en[2]),
      .comparator2_output(dv[3]), .comparator2_output_en(en[3]),
      .capture_compare5_output(dv[4]), .capture_compare5_output_en(en[4]),
      .oscillator_output_pin(dv[5]), .oscillator_output_pin_en(en[5]),
      .quarter_rate_clock_out(dv[6]), .quarter_rate_clock_out_en(en[6]),
      .oscillator_input_pin_en(en[7]),
      .capture_compare4_output(dv[8]), .capture_compare4_output_en(en[8]),
      .i2c_clock_unit2(dv[9]), .i2c_clock_unit2_en(en[9]),
      .spi_clock_unit2(dv[10]), .spi_clock_unit2_en(en[10]),
      .pwm1_output_c(dv[11]), .pwm1_output_c_en(en[11]),
      .i2c_data_unit2(dv[12]), .i2c_data_unit2_en(en[12]),
      .pwm1_output_b(dv[13]), .pwm1_output_b_en(en[13]),
      .spi_out_unit2(dv[14]), .spi_out_unit2_en(en[14]),
      .capture_compare2_output(dv[15]), .capture_compare2_output_en(en[15]),
      .pwm2_output_a(dv[16]), .pwm2_output_a_en(en[16]),
      .pwm1_output_d(dv[17]), .pwm1_output_d_en(en[17]),
      .capture_compare3_output(dv[18]), .capture_compare3_output_en(en[18]),
      .pwm3_output_a(dv[19]), .pwm3_output_a_en(en[19]),
      .pwm2_output_b(dv[20]), .pwm2_output_b_en(en[20]),
      .programming_clock(dv[21]), .programming_clock_en(en[21]),
      .serial2_transmit_clock(dv[22]), .serial2_transmit_clock_en(en[22]),
      .debugger_clock(dv[23]), .debugger_clock_en(en[23]),
      .programming_data(dv[24]), .programming_data_en(en[24]),
      .serial2_receive_data(dv[25]), .serial2_receive_data_en(en[25]),
      .debugger_data(dv[26]), .debugger_data_en(en[26]));
   pad_model i_pad_model_b (.pin_out(b_out), .pin_oe_n(b_oe_n), .pullup_on(pull_b),
      .ext_drv(ext_drv), .ext_lvl(ext_lvl), .pin_in(b_in));
   pad_model i_pad_model_a (.pin_out(a_out), .pin_oe_n(a_oe_n), .pullup_on(8'h00),
      .ext_drv(8'h00), .ext_lvl(8'h00), .pin_in(a_in));
   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic wrap_up;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle;
      repeat (3) @(posedge pclk);
   endtask : settle
   // One APB transfer; waits for pready with a bound instead of assuming a latency.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         miscompares++;
         $display("[FAIL] %0t no pready within the wait limit", $time);
         wrap_up;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, experr});
   endtask : rd_chk
   // Enables slots from k downward in priority and checks that slot k alone decides the pin.
   task automatic chain(input bit pa, input int b, input int s0, input int s1, input int s2);
      int s[3];
      s = '{s0, s1, s2};
      for (int k = 0; k < 3; k++)
         for (int ph = 0; ph < 2; ph++)
            if (s[k] >= 0)
            begin
               @(posedge pclk);
               for (int j = 0; j < 3; j++)
                  if (s[j] >= 0)
                  begin
                     en[s[j]] <= (j >= k);
                     dv[s[j]] <= (j == k) ^ ph[0];
                  end
               settle;
               chk({31'h0, pa ? a_out[b] : b_out[b]}, {31'h0, ~ph[0]});
               chk({31'h0, pa ? a_oe_n[b] : b_oe_n[b]}, 32'h0);
            end
      en <= '0;
      settle;
      chk({31'h0, pa ? a_oe_n[b] : b_oe_n[b]}, 32'h1);
   endtask : chain
   // -------------------------------------------------------------------
   // Stimulus
   // -------------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {en, dv, ext_drv, ext_lvl} = '0;
      miscompares = 0;
      comparisons = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      chk({24'h0, ana_b}, 32'h3F);
      chk({24'h0, ana_a}, 32'h00);
      chk({24'h0, pull_b}, 32'h0);
      chk({24'h0, b_oe_n}, 32'hFF);
      rd_chk(port_mux_pkg::OFF_DIR_B, 32'hFF, 1'b0);
      rd_chk(port_mux_pkg::OFF_PIN_B, 32'hC0, 1'b0);
      rd_chk(12'hFFC, 32'h0, 1'b1);
      wr(port_mux_pkg::OFF_ANA_B, 32'h00);
      wr(port_mux_pkg::OFF_LAT_B, 32'hA5);
      wr(port_mux_pkg::OFF_DIR_B, 32'h0F);
      wr(port_mux_pkg::OFF_PULL_B, 32'hFF);
      wr(port_mux_pkg::OFF_CHG_B, 32'hF0);
      ext_drv <= 8'h0F;
      ext_lvl <= 8'h0C;
      settle;
      chk({24'h0, b_oe_n}, 32'h0F);
      chk({28'h0, b_out[7:4]}, 32'hA);
      chk({24'h0, pull_b}, 32'h0F);
      chk({28'h0, watch_b}, 32'h0);
      rd_chk(port_mux_pkg::OFF_LAT_B, 32'hA5, 1'b0);
      rd_chk(port_mux_pkg::OFF_PIN_B, 32'hAC, 1'b0);
      wr(port_mux_pkg::OFF_PIN_B, 32'h5A);
      rd_chk(port_mux_pkg::OFF_LAT_B, 32'h5A, 1'b0);
      wr(port_mux_pkg::OFF_DIR_B, 32'hFF);
      wr(port_mux_pkg::OFF_ANA_B, 32'hFF);
      wr(port_mux_pkg::OFF_ANA_A, 32'h2F);
      ext_drv <= 8'h00;
      settle;
      chk({28'h0, watch_b}, 32'h0);
      chk({24'h0, ana_b}, 32'hFF);
      chk({24'h0, ana_a}, 32'h2F);
      chain(1'b0, 0, 8, -1, -1);
      chain(1'b0, 1, 9, 10, 11);
      chain(1'b0, 2, 12, 13, -1);
      chain(1'b0, 3, 14, 15, 16);
      chain(1'b0, 4, 17, -1, -1);
      chain(1'b0, 5, 18, 19, 20);
      chain(1'b0, 6, 21, 22, 23);
      chain(1'b0, 7, 24, 25, 26);
      chain(1'b1, 4, 0, 2, 4);
      chain(1'b1, 5, 1, 3, -1);
      chain(1'b1, 6, 5, 6, -1);
      wr(port_mux_pkg::OFF_ANA_B, 32'h00);
      settle;
      chk({28'h0, watch_b}, 32'hF);
      wr(port_mux_pkg::OFF_LAT_B, 32'h00);
      wr(port_mux_pkg::OFF_DIR_B, 32'hBF);
      wr(port_mux_pkg::OFF_LAT_A, 32'h8F);
      wr(port_mux_pkg::OFF_DIR_A, 32'h00);
      en[23] <= 1'b1;
      dv[23] <= 1'b1;
      settle;
      chk({31'h0, b_out[6]}, 32'h0);
      chk({24'h0, a_out}, 32'h8F);
      en[7] <= 1'b1;
      settle;
      chk({24'h0, a_oe_n}, 32'h80);
      wrap_up;
   end
   // The full sequence runs a few hundred cycles; the watchdog allows ample margin.
   initial
   begin
      #100000;
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up;
   end
   always #2.5 pclk = ~pclk;
endmodule : testbench
`default_nettype wire
